// [dv/dcdr_env_model.sv]
`timescale 1ns/1ps

module dcdr_env_model (
  input wire logic i_clk_sys,
  input wire logic [4:0] i_cfg,
  output logic o_is_director_one,
  output logic o_pwr_off_ctl,
  output logic o_pwr_off_bd1,
  output logic o_pwr_off_bd2,
  output logic o_expanded_stg
);
  // Straps and supply monitors are slow levels; settle a cycle later
  always @(posedge i_clk_sys) begin
    {o_is_director_one, o_pwr_off_ctl, o_pwr_off_bd1, o_pwr_off_bd2,
      o_expanded_stg} <= i_cfg;
  end
endmodule : dcdr_env_model

// [dv/director_common_diag_registers_tb.sv]
`timescale 1ns/1ps
`include "dcdr_defs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  err_count++; $display("BAD %s exp=%h got=%h", nm, e, g); end end

module director_common_diag_registers_tb;
  localparam int unsigned TMR = 200;
  localparam logic [7:0] AR = `DCDR_EXT_ADDR_REG;
  localparam logic [7:0] DR = `DCDR_EXT_DATA_REG;
  logic clk_sys, rstn, ir_wr, ir_rd, src_aux, comm_xfer, irq_save;
  logic [7:0] ext_addr, wdata, rdata, buf_ptr, ind_addr;
  logic rvalid, req_hon, sd1_ind, clamp_par, sa_dec, ctl_dec;
  logic is_d1, pwr_ctl, pwr_bd1, pwr_bd2, exp_stg;
  logic [4:0] env_cfg;
  logic [31:0] comm_force, exp32;
  logic [15:0] stor_force, exp16;
  logic [7:0] mbx0, mbx1, mbx2, mbx3, mbx4;
  wire [39:0] mbx_all = {mbx4, mbx3, mbx2, mbx1, mbx0};
  int err_count, check_count, cyc;

  dcdr_env_model i_env (.i_clk_sys(clk_sys), .i_cfg(env_cfg),
    .o_is_director_one(is_d1), .o_pwr_off_ctl(pwr_ctl),
    .o_pwr_off_bd1(pwr_bd1), .o_pwr_off_bd2(pwr_bd2),
    .o_expanded_stg(exp_stg));

  dcdr_regs #(.TIMER_CYCLES(TMR)) i_dut (.i_clk_sys(clk_sys),
    .i_rstn(rstn), .i_ir_wr(ir_wr), .i_ir_rd(ir_rd),
    .i_ir_ext_addr(ext_addr), .i_ir_wdata(wdata), .i_src_aux(src_aux),
    .i_comm_xfer(comm_xfer), .i_irq_save(irq_save),
    .i_is_director_one(is_d1), .i_pwr_off_ctl(pwr_ctl),
    .i_pwr_off_bd1(pwr_bd1), .i_pwr_off_bd2(pwr_bd2),
    .i_expanded_stg(exp_stg), .o_ir_rdata(rdata), .o_ir_rvalid(rvalid),
    .o_aux_ctl(mbx0), .o_m2a_mbx1(mbx1), .o_m2a_mbx2(mbx2),
    .o_a2m_mbx1(mbx3), .o_a2m_mbx2(mbx4), .o_comm_buf_ptr(buf_ptr),
    .o_indirect_addr(ind_addr),
    .o_force_req_honored(req_hon), .o_comm_force(comm_force),
    .o_sd1_indication(sd1_ind), .o_stor_force(stor_force),
    .o_clamp_incr_parity(clamp_par), .o_force_sa_decode(sa_dec),
    .o_force_ctl_decode(ctl_dec));

  task automatic give_verdict();
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // One strobe cycle, then an idle cycle so strobes never merge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    ir_wr = w;
    ir_rd = !w;
    ext_addr = a;
    wdata = d;
    @(posedge clk_sys);
    #1;
    ir_wr = 1'b0;
    ir_rd = 1'b0;
  endtask : bus

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, AR, idx);
    bus(1'b1, DR, d);
  endtask : wr_reg

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK("read valid", 1'b1, rvalid)
    `CHK(nm, e, rdata)
  endtask : rd_chk

  task automatic rd_reg(input string nm, input logic [7:0] idx,
                        input logic [7:0] e);
    bus(1'b1, AR, idx);
    rd_chk(nm, DR, e);
  endtask : rd_reg

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    rstn = 1'b0;
    ir_wr = 1'b0;
    ir_rd = 1'b0;
    ext_addr = 8'h00;
    wdata = 8'h00;
    src_aux = 1'b0;
    comm_xfer = 1'b0;
    irq_save = 1'b0;
    env_cfg = 5'b10101;
    repeat (12) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    `CHK("comm force rst", 32'h0, comm_force)
    `CHK("stor force rst", 16'h0, stor_force)
    // Past the first overflow, well before the second
    repeat (TMR + 20) @(posedge clk_sys);
    rd_reg("stat four", `DCDR_IDX_STAT_FOUR, 8'h4A);
    bus(1'b1, AR, `DCDR_SPOP_CLR_TMR);
    rd_chk("stat four clr", DR, 8'h42);
    rd_reg("stat five", `DCDR_IDX_STAT_FIVE, 8'h01);
    env_cfg = 5'b01010;
    rd_reg("stat four d2", `DCDR_IDX_STAT_FOUR, 8'h25);
    rd_reg("stat five off", `DCDR_IDX_STAT_FIVE, 8'h00);
    // Indices 40-42 are sent by main, 43-44 by aux
    for (int i = 0; i < 5; i++) begin
      src_aux = (i >= 3);
      wr_reg(8'h40 + 8'(i), 8'hA0 + 8'(i));
      src_aux = (i < 3);
      wr_reg(8'h40 + 8'(i), 8'h5F);
      rd_reg("mbx other", 8'h40 + 8'(i), 8'hA0 + 8'(i));
      src_aux = (i >= 3);
      rd_reg("mbx sender", 8'h40 + 8'(i), 8'hA0 + 8'(i));
      `CHK("mbx out", 8'hA0 + 8'(i), mbx_all[8*i +: 8])
    end
    src_aux = 1'b0;
    for (int c = 0; c < 32; c++) begin
      wr_reg(`DCDR_IDX_COMM_ADI, {c[0], 2'b00, 5'(c)});
      exp32 = (c == 0 || c == 14 || c == 15) ? 32'h0 : 32'h1 << c;
      if (c < 16) `CHK("comm lo", exp32, comm_force)
      else `CHK("comm hi", exp32, comm_force)
      `CHK("comm 6/7", exp32[7:4], comm_force[7:4])
      `CHK("comm 11-13", exp32[28:17], comm_force[28:17])
      `CHK("req honored", c[0], req_hon)
      `CHK("sd1 ind", (c == 10), sd1_ind)
      rd_chk("comm reg", DR, {c[0], 2'b00, 5'(c)});
    end
    env_cfg = 5'b10000;
    wr_reg(`DCDR_IDX_COMM_ADI, 8'h0A);
    `CHK("sd1 ind d1", 1'b0, sd1_ind)
    wr_reg(`DCDR_IDX_COMM_ADI, 8'h00);
    `CHK("sd1 ind plain", 1'b1, sd1_ind)
    for (int c = 0; c < 16; c++) begin
      wr_reg(`DCDR_IDX_STOR_ADI, {4'(c), 4'(c) & 4'hE});
      exp16 = (c == 0 || c == 15) ? 16'h0 : 16'h1 << c;
      `CHK("stor force", exp16, stor_force)
      `CHK("stor bits", c[3:1], {clamp_par, sa_dec, ctl_dec})
    end
    wr_reg(`DCDR_IDX_COMM_PTR, 8'hFE);
    bus(1'b1, AR, `DCDR_IDX_COMM_DATA);
    bus(1'b1, DR, 8'h11);
    `CHK("ptr idle", 8'hFE, buf_ptr)
    comm_xfer = 1'b1;
    bus(1'b1, DR, 8'h22);
    bus(1'b0, DR, 8'h00);
    bus(1'b1, DR, 8'h33);
    `CHK("ptr wrap", 8'h01, buf_ptr)
    comm_xfer = 1'b0;
    bus(1'b1, AR, `DCDR_IDX_M2A_MBX1);
    @(posedge clk_sys);
    #1;
    irq_save = 1'b1;
    @(posedge clk_sys);
    #1;
    irq_save = 1'b0;
    bus(1'b1, AR, `DCDR_IDX_COMM_ADI);
    bus(1'b1, AR, `DCDR_SPOP_RESTORE);
    @(posedge clk_sys);
    #1;
    `CHK("restored addr", `DCDR_IDX_M2A_MBX1, ind_addr)
    bus(1'b1, AR, `DCDR_SPOP_FIRST);
    `CHK("spop keeps addr", `DCDR_IDX_M2A_MBX1, ind_addr)
    rd_reg("shadow", `DCDR_IDX_SHADOW, `DCDR_IDX_M2A_MBX1);
    rd_reg("unmapped", 8'h7E, 8'h00);
    rd_chk("other ext", 8'h33, 8'h00);
    give_verdict();
  end
endmodule : director_common_diag_registers_tb

// [hdl/dcdr_defs.svh]
`ifndef DCDR_DEFS_SVH
`define DCDR_DEFS_SVH

// External addresses on the indirect register bus
`define DCDR_EXT_ADDR_REG 8'h1B
`define DCDR_EXT_DATA_REG 8'h0F

// Indirect register indices (selected through the address register)
`define DCDR_IDX_AUX_CTL 8'h40
`define DCDR_IDX_M2A_MBX1 8'h41
`define DCDR_IDX_M2A_MBX2 8'h42
`define DCDR_IDX_A2M_MBX1 8'h43
`define DCDR_IDX_A2M_MBX2 8'h44
`define DCDR_IDX_COMM_ADI 8'h45
`define DCDR_IDX_COMM_PTR 8'h46
`define DCDR_IDX_COMM_DATA 8'h47
`define DCDR_IDX_STOR_ADI 8'h48
`define DCDR_IDX_STAT_FOUR 8'h49
`define DCDR_IDX_STAT_FIVE 8'h4A
`define DCDR_IDX_SHADOW 8'h4B

// Special operation codes written to the address register
`define DCDR_SPOP_FIRST 8'hD0
`define DCDR_SPOP_LAST 8'hD9
`define DCDR_SPOP_RESTORE 8'hD1
`define DCDR_SPOP_CLR_TMR 8'hD9

// Reset values
`define DCDR_RST_BYTE 8'h00
`define DCDR_RST_COMM_CODE 5'h00
`define DCDR_RST_STOR_CODE 4'h0

// Communication fault-injection fields (bit 0 is the MSB)
`define DCDR_CADI_REQ_HON 7
`define DCDR_CADI_CODE_HI 4
`define DCDR_CADI_CODE_LO 0
`define DCDR_COMM_CODE_INV_SD1 5'h0A
// Codes 00, 0E and 0F produce no forcing
`define DCDR_COMM_FORCE_MASK 32'hFFFF_3FFE

// Storage address fault-injection fields
`define DCDR_SADI_CODE_HI 7
`define DCDR_SADI_CODE_LO 4
`define DCDR_SADI_INCR_PAR 3
`define DCDR_SADI_SA_DEC 2
`define DCDR_SADI_CTL_DEC 1
// Codes 0 and F produce no forcing
`define DCDR_STOR_FORCE_MASK 16'h7FFE

// Overflow timer
`define DCDR_TIMER_MS 57
`define DCDR_CLK_KHZ 100000
`define DCDR_TIMER_CYCLES (`DCDR_TIMER_MS * `DCDR_CLK_KHZ)

`endif

// [hdl/dcdr_pkg.sv]
package dcdr_pkg;
  typedef logic [7:0] dcdr_byte_t;
  typedef logic [4:0] dcdr_comm_code_t;
  typedef logic [3:0] dcdr_stor_code_t;
endpackage : dcdr_pkg

// [hdl/dcdr_regs.sv]
// Functional notes
// RULE_01: Aux control readable by both, main writes only
// RULE_02: Mailboxes writable only by their sending processor
// RULE_03: Bit 0 forces request-honored active
// RULE_04: Five-bit forcing code held, reset to zero
// RULE_05: Codes 01-03 force parity and decode errors
// RULE_06: Codes 04/06 inhibit or force other request
// RULE_07: Codes 05,07,08,09 force buffer and clock checks
// RULE_08: Code 0A inverts director-one indication
// RULE_09: Codes 0B-0D force checks, 0E-0F nothing
// RULE_10: Codes 10,15 force ALU control checks
// RULE_11: Code 11 holds transfer bus parity active
// RULE_12: Codes 12,13,1D force overrun or underrun
// RULE_13: Codes 14,19,1C disturb indirect bus gates
// RULE_14: Codes 16-18,1A,1B,1E,1F force parity checks
// RULE_15: Buffer pointer increments on each data access; the code steps it only while i_comm_xfer is high
// RULE_16: Storage code 0 normal, 1-3 force checks
// RULE_17: Storage codes 4-9 force refresh/data checks
// RULE_18: Storage codes A-E force gate/select checks
// RULE_19: Storage bits 4-6 clamp parity, force decodes
// RULE_20: Status four shows identity, overflow, power-off
// RULE_21: Status five bit 7 shows expanded storage
// RULE_22: Shadow keeps address register copy on interrupt
// RULE_23: Restore op loads shadow on next cycle
// RULE_24: Op D9 clears the timer overflow flag
`timescale 1ns/1ps
`include "dcdr_defs.svh"

module dcdr_regs #(
  parameter int unsigned TIMER_CYCLES = `DCDR_TIMER_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ir_wr,
  input wire logic i_ir_rd,
  input wire logic [7:0] i_ir_ext_addr,
  input wire logic [7:0] i_ir_wdata,
  input wire logic i_src_aux,
  input wire logic i_comm_xfer,
  input wire logic i_irq_save,
  input wire logic i_is_director_one,
  input wire logic i_pwr_off_ctl,
  input wire logic i_pwr_off_bd1,
  input wire logic i_pwr_off_bd2,
  input wire logic i_expanded_stg,
  output logic [7:0] o_ir_rdata,
  output logic o_ir_rvalid,
  output logic [7:0] o_aux_ctl,
  output logic [7:0] o_m2a_mbx1,
  output logic [7:0] o_m2a_mbx2,
  output logic [7:0] o_a2m_mbx1,
  output logic [7:0] o_a2m_mbx2,
  output logic [7:0] o_comm_buf_ptr,
  output logic [7:0] o_indirect_addr,
  output logic o_force_req_honored,
  output logic [31:0] o_comm_force,
  output logic o_sd1_indication,
  output logic [15:0] o_stor_force,
  output logic o_clamp_incr_parity,
  output logic o_force_sa_decode,
  output logic o_force_ctl_decode
);

  localparam int unsigned TW = $clog2(TIMER_CYCLES + 1);
  localparam logic [TW-1:0] TIMER_LAST = TW'(TIMER_CYCLES - 1);
  localparam logic [TW-1:0] TIMER_ZERO = '0;
  localparam logic [TW-1:0] TIMER_ONE = TW'(1);

  dcdr_pkg::dcdr_byte_t addr_reg, addr_next;
  dcdr_pkg::dcdr_byte_t shadow_reg, shadow_next;
  dcdr_pkg::dcdr_byte_t aux_ctl_reg;
  dcdr_pkg::dcdr_byte_t m2a1_reg, m2a2_reg, a2m1_reg, a2m2_reg;
  dcdr_pkg::dcdr_byte_t comm_adi_reg, stor_adi_reg;
  dcdr_pkg::dcdr_byte_t ptr_reg, ptr_next;
  dcdr_pkg::dcdr_byte_t rdata_reg, rdata_next;
  dcdr_pkg::dcdr_byte_t rd_word;
  dcdr_pkg::dcdr_byte_t stat_four, stat_five;
  dcdr_pkg::dcdr_comm_code_t comm_code;
  dcdr_pkg::dcdr_stor_code_t stor_code;
  logic rvalid_reg;
  logic restore_pend_reg;
  logic tmr_ovf_reg, tmr_ovf_next;
  logic [TW-1:0] tmr_cnt_reg, tmr_cnt_next;
  logic [31:0] comm_hot;
  logic [15:0] stor_hot;

  // Bus decode
  wire acc_addr = i_ir_ext_addr == `DCDR_EXT_ADDR_REG;
  wire acc_data = i_ir_ext_addr == `DCDR_EXT_DATA_REG;
  wire wr_addr = i_ir_wr && acc_addr;
  wire wr_data = i_ir_wr && acc_data;
  wire rd_data = i_ir_rd && acc_data;
  wire is_spop = (i_ir_wdata >= `DCDR_SPOP_FIRST) &&
                 (i_ir_wdata <= `DCDR_SPOP_LAST);
  wire wr_plain_addr = wr_addr && !is_spop;
  wire op_restore = wr_addr && (i_ir_wdata == `DCDR_SPOP_RESTORE);
  wire op_clr_tmr = wr_addr && (i_ir_wdata == `DCDR_SPOP_CLR_TMR);
  wire from_main = !i_src_aux;

  // Per-register write enables
  wire we_ctl = wr_data && from_main &&
                addr_reg == `DCDR_IDX_AUX_CTL; // RULE_01
  wire we_m2a1 = wr_data && from_main &&
                 addr_reg == `DCDR_IDX_M2A_MBX1; // RULE_02
  wire we_m2a2 = wr_data && from_main &&
                 addr_reg == `DCDR_IDX_M2A_MBX2; // RULE_02
  wire we_a2m1 = wr_data && i_src_aux &&
                 addr_reg == `DCDR_IDX_A2M_MBX1; // RULE_02
  wire we_a2m2 = wr_data && i_src_aux &&
                 addr_reg == `DCDR_IDX_A2M_MBX2; // RULE_02
  wire we_cadi = wr_data && addr_reg == `DCDR_IDX_COMM_ADI;
  wire we_sadi = wr_data && addr_reg == `DCDR_IDX_STOR_ADI;
  wire we_ptr = wr_data && addr_reg == `DCDR_IDX_COMM_PTR;
  wire we_shadow = wr_data && addr_reg == `DCDR_IDX_SHADOW;
  // Each data-register access during a transfer steps the pointer
  wire ptr_inc = (wr_data || rd_data) && i_comm_xfer &&
                 addr_reg == `DCDR_IDX_COMM_DATA; // RULE_15
  wire timer_full = tmr_cnt_reg == TIMER_LAST;

  // Restore beats a plain address write landing in the same cycle
  assign addr_next = restore_pend_reg ? shadow_reg :
                     wr_plain_addr ? i_ir_wdata : addr_reg; // RULE_23
  assign shadow_next = i_irq_save ? addr_reg :
                       we_shadow ? i_ir_wdata : shadow_reg; // RULE_22
  assign ptr_next = we_ptr ? i_ir_wdata :
                    ptr_inc ? 8'(ptr_reg + 8'h01) : ptr_reg; // RULE_15
  assign tmr_cnt_next = timer_full ? TIMER_ZERO :
                        TW'(tmr_cnt_reg + TIMER_ONE);
  // Overflow set wins over a clear in the same cycle
  assign tmr_ovf_next = timer_full ? 1'b1 :
                        op_clr_tmr ? 1'b0 : tmr_ovf_reg; // RULE_24

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      addr_reg <= `DCDR_RST_BYTE;
      shadow_reg <= `DCDR_RST_BYTE;
      restore_pend_reg <= 1'b0;
      ptr_reg <= `DCDR_RST_BYTE;
    end else begin
      addr_reg <= addr_next;
      shadow_reg <= shadow_next;
      restore_pend_reg <= op_restore; // RULE_23
      ptr_reg <= ptr_next;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      aux_ctl_reg <= `DCDR_RST_BYTE;
      m2a1_reg <= `DCDR_RST_BYTE;
      m2a2_reg <= `DCDR_RST_BYTE;
      a2m1_reg <= `DCDR_RST_BYTE;
      a2m2_reg <= `DCDR_RST_BYTE;
    end else begin
      if (we_ctl) aux_ctl_reg <= i_ir_wdata;
      if (we_m2a1) m2a1_reg <= i_ir_wdata;
      if (we_m2a2) m2a2_reg <= i_ir_wdata;
      if (we_a2m1) a2m1_reg <= i_ir_wdata;
      if (we_a2m2) a2m2_reg <= i_ir_wdata;
    end
  end

  // Forcing codes stay until software rewrites them
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      comm_adi_reg <= `DCDR_RST_BYTE; // RULE_04
      stor_adi_reg <= `DCDR_RST_BYTE; // RULE_16
    end else begin
      if (we_cadi) comm_adi_reg <= i_ir_wdata;
      if (we_sadi) stor_adi_reg <= i_ir_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      tmr_cnt_reg <= TIMER_ZERO;
      tmr_ovf_reg <= 1'b0;
    end else begin
      tmr_cnt_reg <= tmr_cnt_next;
      tmr_ovf_reg <= tmr_ovf_next; // RULE_20
    end
  end

  // Fault-injection decode; combinational so forcing acts at once
  assign comm_code = comm_adi_reg[`DCDR_CADI_CODE_HI:`DCDR_CADI_CODE_LO];
  assign stor_code = stor_adi_reg[`DCDR_SADI_CODE_HI:`DCDR_SADI_CODE_LO];

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_comm
      assign comm_hot[gi] = comm_code == 5'(gi);
    end
    for (gi = 0; gi < 16; gi++) begin : g_stor
      assign stor_hot[gi] = stor_code == 4'(gi);
    end
  endgenerate

  // RULE_05 RULE_06 RULE_07 RULE_09 RULE_10 RULE_11 RULE_12 RULE_13
  assign o_comm_force = comm_hot & `DCDR_COMM_FORCE_MASK; // RULE_14
  // RULE_16 RULE_17
  assign o_stor_force = stor_hot & `DCDR_STOR_FORCE_MASK; // RULE_18
  assign o_force_req_honored = comm_adi_reg[`DCDR_CADI_REQ_HON]; // RULE_03
  assign o_sd1_indication = i_is_director_one ^
    (comm_code == `DCDR_COMM_CODE_INV_SD1); // RULE_08
  assign o_clamp_incr_parity = stor_adi_reg[`DCDR_SADI_INCR_PAR]; // RULE_19
  assign o_force_sa_decode = stor_adi_reg[`DCDR_SADI_SA_DEC]; // RULE_19
  assign o_force_ctl_decode = stor_adi_reg[`DCDR_SADI_CTL_DEC]; // RULE_19

  // Status bytes; bit 0 is the MSB, unused bits read zero
  assign stat_four = {1'b0, o_sd1_indication, !i_is_director_one, 1'b0,
                      tmr_ovf_reg, i_pwr_off_ctl, i_pwr_off_bd1,
                      i_pwr_off_bd2}; // RULE_20
  assign stat_five = {7'h00, i_expanded_stg}; // RULE_21

  always_comb begin
    unique case (addr_reg)
      `DCDR_IDX_AUX_CTL: rd_word = aux_ctl_reg; // RULE_01
      `DCDR_IDX_M2A_MBX1: rd_word = m2a1_reg;
      `DCDR_IDX_M2A_MBX2: rd_word = m2a2_reg;
      `DCDR_IDX_A2M_MBX1: rd_word = a2m1_reg;
      `DCDR_IDX_A2M_MBX2: rd_word = a2m2_reg;
      `DCDR_IDX_COMM_ADI: rd_word = comm_adi_reg;
      `DCDR_IDX_COMM_PTR: rd_word = ptr_reg;
      `DCDR_IDX_STOR_ADI: rd_word = stor_adi_reg;
      `DCDR_IDX_STAT_FOUR: rd_word = stat_four;
      `DCDR_IDX_STAT_FIVE: rd_word = stat_five;
      `DCDR_IDX_SHADOW: rd_word = shadow_reg;
      default: rd_word = `DCDR_RST_BYTE;
    endcase
  end

  assign rdata_next = !i_ir_rd ? rdata_reg :
                      acc_addr ? addr_reg :
                      acc_data ? rd_word : `DCDR_RST_BYTE;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_reg <= `DCDR_RST_BYTE;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= i_ir_rd;
    end
  end

  assign o_ir_rdata = rdata_reg;
  assign o_ir_rvalid = rvalid_reg;
  assign o_aux_ctl = aux_ctl_reg;
  assign o_m2a_mbx1 = m2a1_reg;
  assign o_m2a_mbx2 = m2a2_reg;
  assign o_a2m_mbx1 = a2m1_reg;
  assign o_a2m_mbx2 = a2m2_reg;
  assign o_comm_buf_ptr = ptr_reg;
  assign o_indirect_addr = addr_reg;

  chk_ctl_aux_block: assert property (@(posedge i_clk_sys) // RULE_01
    disable iff (!i_rstn)
    (wr_data && i_src_aux && addr_reg == `DCDR_IDX_AUX_CTL)
    |=> $stable(o_aux_ctl)) else $error("aux wrote control");

  chk_mbx_main_block: assert property (@(posedge i_clk_sys) // RULE_02
    disable iff (!i_rstn)
    (wr_data && from_main && addr_reg == `DCDR_IDX_A2M_MBX1)
    |=> $stable(o_a2m_mbx1)) else $error("main wrote aux mailbox");

  chk_ptr_step_one: assert property (@(posedge i_clk_sys) // RULE_15
    disable iff (!i_rstn)
    ptr_inc |=> o_comm_buf_ptr == 8'($past(o_comm_buf_ptr) + 8'h01))
    else $error("pointer did not step by one");

  chk_restore_load: assert property (@(posedge i_clk_sys) // RULE_23
    disable iff (!i_rstn)
    (op_restore && !i_irq_save && !we_shadow)
    |=> ##1 o_indirect_addr == $past(shadow_reg, 2))
    else $error("restore did not load shadow");

  chk_spop_no_addr: assert property (@(posedge i_clk_sys) // RULE_23
    disable iff (!i_rstn)
    (wr_addr && is_spop && !restore_pend_reg) |=> $stable(o_indirect_addr))
    else $error("special op changed address");

  chk_ovf_clear: assert property (@(posedge i_clk_sys) // RULE_24
    disable iff (!i_rstn)
    (op_clr_tmr && !timer_full) |=> !stat_four[3])
    else $error("overflow not cleared");

  chk_ovf_set: assert property (@(posedge i_clk_sys) // RULE_20
    disable iff (!i_rstn)
    timer_full |=> stat_four[3] && tmr_cnt_reg == TIMER_ZERO)
    else $error("overflow not flagged");

  chk_code_zero_idle: assert property (@(posedge i_clk_sys) // RULE_04
    disable iff (!i_rstn)
    comm_code == `DCDR_RST_COMM_CODE |-> o_comm_force == 32'h0000_0000)
    else $error("forcing with code zero");

  chk_sd1_invert: assert property (@(posedge i_clk_sys) // RULE_08
    disable iff (!i_rstn)
    (we_cadi && i_ir_wdata[4:0] == `DCDR_COMM_CODE_INV_SD1)
    |=> o_sd1_indication != i_is_director_one)
    else $error("identity not inverted");

  chk_stor_idle: assert property (@(posedge i_clk_sys) // RULE_16
    disable iff (!i_rstn)
    stor_code == `DCDR_RST_STOR_CODE |-> o_stor_force == 16'h0000)
    else $error("storage forcing with code zero");

  chk_ctl_main_write: assert property (@(posedge i_clk_sys) // RULE_01
    disable iff (!i_rstn)
    we_ctl |=> o_aux_ctl == $past(i_ir_wdata))
    else $error("main write to control lost");

  chk_m2a_aux_block: assert property (@(posedge i_clk_sys) // RULE_02
    disable iff (!i_rstn)
    (wr_data && i_src_aux && addr_reg == `DCDR_IDX_M2A_MBX1)
    |=> $stable(o_m2a_mbx1)) else $error("aux wrote main mailbox");

  chk_m2a2_aux_block: assert property (@(posedge i_clk_sys) // RULE_02
    disable iff (!i_rstn)
    (wr_data && i_src_aux && addr_reg == `DCDR_IDX_M2A_MBX2)
    |=> $stable(o_m2a_mbx2)) else $error("aux wrote second mailbox");

  chk_a2m2_main_block: assert property (@(posedge i_clk_sys) // RULE_02
    disable iff (!i_rstn)
    (wr_data && from_main && addr_reg == `DCDR_IDX_A2M_MBX2)
    |=> $stable(o_a2m_mbx2)) else $error("main wrote second aux box");

  chk_a2m_aux_write: assert property (@(posedge i_clk_sys) // RULE_02
    disable iff (!i_rstn)
    we_a2m1 |=> o_a2m_mbx1 == $past(i_ir_wdata))
    else $error("aux mailbox write lost");

  chk_req_hon_load: assert property (@(posedge i_clk_sys) // RULE_03
    disable iff (!i_rstn)
    we_cadi |=> o_force_req_honored ==
    $past(i_ir_wdata[`DCDR_CADI_REQ_HON]))
    else $error("request honored bit not loaded");

  chk_comm_code_held: assert property (@(posedge i_clk_sys) // RULE_04
    disable iff (!i_rstn)
    !we_cadi |=> $stable(comm_code))
    else $error("forcing code changed unasked");

  chk_ptr_load: assert property (@(posedge i_clk_sys) // RULE_15
    disable iff (!i_rstn)
    we_ptr |=> o_comm_buf_ptr == $past(i_ir_wdata))
    else $error("pointer not loaded");

  chk_ptr_hold: assert property (@(posedge i_clk_sys) // RULE_15
    disable iff (!i_rstn)
    !(we_ptr || ptr_inc) |=> $stable(o_comm_buf_ptr))
    else $error("pointer moved without access");

  chk_shadow_save: assert property (@(posedge i_clk_sys) // RULE_22
    disable iff (!i_rstn)
    i_irq_save |=> shadow_reg == $past(o_indirect_addr))
    else $error("shadow missed address copy");

  chk_sd1_plain: assert property (@(posedge i_clk_sys) // RULE_08
    disable iff (!i_rstn)
    (comm_code != `DCDR_COMM_CODE_INV_SD1)
    |-> o_sd1_indication == i_is_director_one)
    else $error("identity changed without code");

  chk_ovf_hold: assert property (@(posedge i_clk_sys) // RULE_20
    disable iff (!i_rstn)
    (!timer_full && !op_clr_tmr) |=> $stable(tmr_ovf_reg))
    else $error("overflow flag moved");

  chk_sa_decode_load: assert property (@(posedge i_clk_sys) // RULE_19
    disable iff (!i_rstn)
    we_sadi |=> o_force_sa_decode ==
    $past(i_ir_wdata[`DCDR_SADI_SA_DEC]))
    else $error("address decode bit not loaded");

  chk_restore_wins: assert property (@(posedge i_clk_sys) // RULE_23
    disable iff (!i_rstn)
    (restore_pend_reg && wr_plain_addr)
    |=> o_indirect_addr == $past(shadow_reg))
    else $error("plain write beat restore");

endmodule : dcdr_regs
